// ---- core/psl_defines.svh ----
`ifndef PSL_DEFINES_SVH
`define PSL_DEFINES_SVH

// Register offsets
`define PSL_OFF_PORT_EN 16'h3C48
`define PSL_OFF_GLOBAL 16'h4141
`define PSL_OFF_P5_SEL 16'h416E
`define PSL_OFF_P6_SEL 16'h416F
`define PSL_OFF_TIMEOUT 16'h4171
`define PSL_OFF_TOGGLE 16'h4176
`define PSL_OFF_STATUS 16'h41F0

// Reset values
`define PSL_RST_PORT_EN 2'h0
`define PSL_RST_GLOBAL 1'h0
`define PSL_RST_SEL 8'h00
`define PSL_RST_TIMEOUT 3'h5
`define PSL_RST_TOGGLE 8'h05

// Field positions
`define PSL_P5_BIT 5
`define PSL_P6_BIT 6
`define PSL_GLOBAL_BIT 0
`define PSL_PORT_EN_RSVD 8'h9F

// Split pin select codes
`define PSL_P5_SEL_A 8'h42
`define PSL_P5_SEL_B 8'h05
`define PSL_P6_SEL_A 8'h06
`define PSL_P6_SEL_B 8'h04

// Stuck link state code range
`define PSL_STUCK_LO 4'h4
`define PSL_STUCK_HI 4'h9

// Timing, milliseconds in hex: 100, 250, 500, 750, 1000, 2000
`define PSL_TO_MS_1 12'h064
`define PSL_TO_MS_2 12'h0FA
`define PSL_TO_MS_3 12'h1F4
`define PSL_TO_MS_4 12'h2EE
`define PSL_TO_MS_5 12'h3E8
`define PSL_TO_MS_6 12'h7D0
// Toggle base 350 ms, step 10 ms
`define PSL_TOGGLE_BASE_MS 12'h15E
`define PSL_TOGGLE_STEP_MS 12'h00A
`define PSL_CLK_PERIOD_NS 10
`define PSL_MS_NS 1000000

`endif

// ---- core/psl_pkg.sv ----
package psl_pkg;

  typedef struct packed {
    logic out;
    logic oe;
    logic pullup_en;
  } psl_od_pin_t;

  typedef struct packed {
    logic out;
    logic oe;
  } psl_pp_pin_t;

  typedef struct packed {
    logic [3:0] p6;
    logic [3:0] p5;
  } psl_link_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WATCH,
    ST_PULSE
  } psl_watch_st_t;

endpackage

// ---- core/psl_link_watch.sv ----
`timescale 1ns/1ps
`include "psl_defines.svh"
module psl_link_watch import psl_pkg::*; #(
  parameter int CYCLES_PER_MS = `PSL_MS_NS / `PSL_CLK_PERIOD_NS
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_active,
  input wire logic [11:0] i_timeout_ms,
  input wire logic [11:0] i_toggle_ms,
  input wire logic [3:0] i_link_state,
  output logic o_pulse
);

  psl_watch_st_t st, next_st;
  logic [31:0] cnt, next_cnt;
  logic [3:0] prev_state;
  wire [31:0] timeout_cyc = 32'(i_timeout_ms) * 32'(CYCLES_PER_MS);
  wire [31:0] toggle_cyc = 32'(i_toggle_ms) * 32'(CYCLES_PER_MS);
  wire stuck_code = (i_link_state >= `PSL_STUCK_LO) && (i_link_state <= `PSL_STUCK_HI);
  wire held = stuck_code && (i_link_state == prev_state);
  wire watch_on = i_active && (i_timeout_ms != 12'h000);

  always_comb begin
    next_st = st;
    next_cnt = cnt;
    unique case (st)
      ST_IDLE: begin
        next_cnt = 32'h0;
        if (watch_on) begin
          next_st = ST_WATCH;
        end
      end
      ST_WATCH: begin
        if (!watch_on) begin
          next_st = ST_IDLE;
          next_cnt = 32'h0;
        end else if (!held) begin
          next_cnt = 32'h0;
        end else if (cnt >= timeout_cyc - 32'h1) begin
          next_st = ST_PULSE;
          next_cnt = 32'h0;
        end else begin
          next_cnt = cnt + 32'h1;
        end
      end
      ST_PULSE: begin
        if (!i_active) begin
          next_st = ST_IDLE;
          next_cnt = 32'h0;
        end else if (cnt >= toggle_cyc - 32'h1) begin
          next_st = ST_WATCH;
          next_cnt = 32'h0;
        end else begin
          next_cnt = cnt + 32'h1;
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st <= ST_IDLE;
      cnt <= 32'h0;
      prev_state <= 4'h0;
      o_pulse <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      prev_state <= i_link_state;
      o_pulse <= (next_st == ST_PULSE);
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence s_pulse_start;
    $rose(o_pulse);
  endsequence

  sequence s_pulse_done;
    $fell(o_pulse) && (st == ST_WATCH);
  endsequence

  stuck_timeout_a: assert property (
    s_pulse_start |-> $past(held) && ($past(cnt) == timeout_cyc - 32'h1)
  ) else $error("Split pulse started without full stuck timeout");

  pulse_width_a: assert property (
    s_pulse_done |-> $past(cnt) == toggle_cyc - 32'h1
  ) else $error("Split low pulse ended at wrong length");

  moving_link_a: assert property (
    (st == ST_WATCH && !held) |=> cnt == 32'h0
  ) else $error("Timer not cleared on valid link");

  timer_restart_a: assert property (
    s_pulse_start |-> cnt == 32'h0 ##1 (cnt == 32'h1 || !o_pulse)
  ) else $error("Timer not restarted at timeout");

endmodule // psl_link_watch

// ---- core/psl_top.sv ----
`timescale 1ns/1ps
`include "psl_defines.svh"
// Contract
// - Power off: drive control pin low.
// - Power on: release driver, enable pull-up.
// - Poly fuse: low pin while on flags overcurrent.
// - Splitting exists only on ports 5, 6.
// - Control pin keeps USB 2.0; split pin SuperSpeed.
// - No overcurrent sensing on split pin.
// - Per-port enable bits 5, 6; others reserved.
// - Global bit 0 must also be set.
// - Stuck link past timeout pulses split pin.
// - Link changing states counts as valid.
// - Stuck means one state 0x4-0x9 throughout.
// - Timeout expiry restarts the timer.
// - Timeout resets to 0x05; 0x00 disables.
// - OTP value overrides timeout register.
// - Low pulse length from toggle register.
// - Timeout codes map 0 to 2 seconds.
// - Toggle 350 ms plus 10 ms steps.
module psl_top import psl_pkg::*; #(
  parameter int NUM_PORTS = 6,
  parameter int CYCLES_PER_MS = `PSL_MS_NS / `PSL_CLK_PERIOD_NS
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [15:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  input wire logic i_otp_timeout_vld,
  input wire logic [2:0] i_otp_timeout,
  input wire logic i_poly_fuse_mode,
  input wire logic [NUM_PORTS-1:0] i_port_power_en,
  input wire logic [NUM_PORTS-1:0] i_pwr_ctl_in,
  output psl_od_pin_t [NUM_PORTS-1:0] o_pwr_ctl,
  output logic [NUM_PORTS-1:0] o_overcurrent,
  input wire psl_link_t i_link_state,
  output psl_pp_pin_t [3:0] o_split_gpio
);

  function automatic logic [11:0] f_timeout_ms(input logic [2:0] code);
    logic [11:0] ms;
    ms = 12'h000;
    case (code)
      3'h1: ms = `PSL_TO_MS_1;
      3'h2: ms = `PSL_TO_MS_2;
      3'h3: ms = `PSL_TO_MS_3;
      3'h4: ms = `PSL_TO_MS_4;
      3'h5: ms = `PSL_TO_MS_5;
      3'h6: ms = `PSL_TO_MS_6;
      default: ms = 12'h000;
    endcase
    return ms;
  endfunction

  function automatic logic [1:0] f_sel_opt(input logic [7:0] code, input logic [7:0] code_a,
                                           input logic [7:0] code_b);
    return {code == code_b, code == code_a};
  endfunction

  // Register file
  logic [1:0] split_en_bits;
  logic split_global;
  logic [7:0] p5_sel;
  logic [7:0] p6_sel;
  logic [2:0] timeout_sel;
  logic [7:0] toggle_sel;

  wire hit_port_en = (i_reg_addr == `PSL_OFF_PORT_EN);
  wire hit_global = (i_reg_addr == `PSL_OFF_GLOBAL);
  wire hit_p5_sel = (i_reg_addr == `PSL_OFF_P5_SEL);
  wire hit_p6_sel = (i_reg_addr == `PSL_OFF_P6_SEL);
  wire hit_timeout = (i_reg_addr == `PSL_OFF_TIMEOUT);
  wire hit_toggle = (i_reg_addr == `PSL_OFF_TOGGLE);
  wire hit_status = (i_reg_addr == `PSL_OFF_STATUS);
  wire [1:0] wr_port_bits = {i_reg_wdata[`PSL_P6_BIT], i_reg_wdata[`PSL_P5_BIT]};

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      split_en_bits <= `PSL_RST_PORT_EN;
      split_global <= `PSL_RST_GLOBAL;
      p5_sel <= `PSL_RST_SEL;
      p6_sel <= `PSL_RST_SEL;
      timeout_sel <= `PSL_RST_TIMEOUT;
      toggle_sel <= `PSL_RST_TOGGLE;
    end else if (i_reg_wr) begin
      // Only ports 5 and 6 have storage; reserved bits are dropped
      if (hit_port_en) begin
        split_en_bits <= wr_port_bits;
      end
      if (hit_global) begin
        split_global <= i_reg_wdata[`PSL_GLOBAL_BIT];
      end
      if (hit_p5_sel) begin
        p5_sel <= i_reg_wdata;
      end
      if (hit_p6_sel) begin
        p6_sel <= i_reg_wdata;
      end
      if (hit_timeout) begin
        timeout_sel <= i_reg_wdata[2:0];
      end
      if (hit_toggle) begin
        toggle_sel <= i_reg_wdata;
      end
    end
  end

  // Split control
  logic [1:0] pulse;
  wire [1:0] split_on = {2{split_global}} & split_en_bits;
  wire [2:0] eff_timeout = i_otp_timeout_vld ? i_otp_timeout : timeout_sel;
  wire [11:0] timeout_ms = f_timeout_ms(eff_timeout);
  wire [11:0] toggle_ms = `PSL_TOGGLE_BASE_MS + 12'(toggle_sel) * `PSL_TOGGLE_STEP_MS;
  wire [1:0] opt5 = f_sel_opt(p5_sel, `PSL_P5_SEL_A, `PSL_P5_SEL_B);
  wire [1:0] opt6 = f_sel_opt(p6_sel, `PSL_P6_SEL_A, `PSL_P6_SEL_B);
  wire [3:0] gpio_en = {opt6 & {2{split_on[1]}}, opt5 & {2{split_on[0]}}};
  wire [1:0][3:0] link_st = {i_link_state.p6, i_link_state.p5};

  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_watch
      psl_link_watch #(
        .CYCLES_PER_MS(CYCLES_PER_MS)
      ) u_watch (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_active(split_on[s]),
        .i_timeout_ms(timeout_ms),
        .i_toggle_ms(toggle_ms),
        .i_link_state(link_st[s]),
        .o_pulse(pulse[s])
      );
    end
  endgenerate

  // Split pins drive only; nothing samples them for overcurrent
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_split
      always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
          o_split_gpio[g] <= '0;
        end else begin
          o_split_gpio[g].oe <= gpio_en[g];
          o_split_gpio[g].out <= gpio_en[g] & ~pulse[g/2];
        end
      end

      split_high_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (gpio_en[g] && !pulse[g/2]) |=> (o_split_gpio[g].out && o_split_gpio[g].oe)
      ) else $error("Split pin not high while enabled");

      split_low_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (gpio_en[g] && pulse[g/2]) |=> (!o_split_gpio[g].out && o_split_gpio[g].oe)
      ) else $error("Split pin not low during pulse");

      split_idle_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !gpio_en[g] |=> (o_split_gpio[g] == 2'b00)
      ) else $error("Unowned split pin not released");
    end
  endgenerate

  // Power control pins
  logic [NUM_PORTS-1:0] ctl_meta;
  logic [NUM_PORTS-1:0] ctl_sync;
  logic [NUM_PORTS-1:0] pu_d1;
  logic [NUM_PORTS-1:0] pu_d2;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ctl_meta <= '0;
      ctl_sync <= '0;
    end else begin
      ctl_meta <= i_pwr_ctl_in;
      ctl_sync <= ctl_meta;
    end
  end

  genvar k;
  generate
    for (k = 0; k < NUM_PORTS; k++) begin : g_port
      always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
          o_pwr_ctl[k].out <= 1'b0;
          o_pwr_ctl[k].oe <= 1'b1;
          o_pwr_ctl[k].pullup_en <= 1'b0;
          pu_d1[k] <= 1'b0;
          pu_d2[k] <= 1'b0;
          o_overcurrent[k] <= 1'b0;
        end else begin
          o_pwr_ctl[k].out <= 1'b0;
          o_pwr_ctl[k].oe <= ~i_port_power_en[k];
          o_pwr_ctl[k].pullup_en <= i_port_power_en[k];
          pu_d1[k] <= o_pwr_ctl[k].pullup_en;
          pu_d2[k] <= pu_d1[k];
          // Waits out our own low drive through the synchroniser
          o_overcurrent[k] <= i_poly_fuse_mode & i_port_power_en[k] & pu_d2[k]
                              & ~ctl_sync[k];
        end
      end

      pwr_off_drive_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !i_port_power_en[k] |=> (o_pwr_ctl[k].oe && !o_pwr_ctl[k].out
                                 && !o_pwr_ctl[k].pullup_en)
      ) else $error("Disabled port pin not driven low");

      pwr_on_release_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_port_power_en[k] [*3] |=> (!o_pwr_ctl[k].oe && o_pwr_ctl[k].pullup_en)
      ) else $error("Enabled port pin not released");

      poly_oc_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        o_overcurrent[k] |-> $past(i_poly_fuse_mode && i_port_power_en[k] && !ctl_sync[k])
      ) else $error("Overcurrent flagged without cause");

      oc_power_off_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !i_port_power_en[k] |=> !o_overcurrent[k]
      ) else $error("Overcurrent flagged on unpowered port");
    end
  endgenerate

  // Register read, answered one cycle after the strobe
  wire [7:0] rd_port_en = {1'b0, split_en_bits[1], split_en_bits[0], 5'h00};
  wire [7:0] rd_status = {4'h0, split_on, pulse};
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    if (hit_port_en) rd_mux = rd_port_en;
    if (hit_global) rd_mux = {7'h00, split_global};
    if (hit_p5_sel) rd_mux = p5_sel;
    if (hit_p6_sel) rd_mux = p6_sel;
    if (hit_timeout) rd_mux = {5'h00, timeout_sel};
    if (hit_toggle) rd_mux = toggle_sel;
    if (hit_status) rd_mux = rd_status;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else begin
      o_reg_rdata <= i_reg_rd ? rd_mux : 8'h00;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  rsvd_bits_zero_a: assert property (
    (i_reg_rd && hit_port_en) |=> (o_reg_rdata & `PSL_PORT_EN_RSVD) == 8'h00
  ) else $error("Reserved split enable bit read nonzero");

  global_gate_a: assert property (
    !split_global |=> (o_split_gpio[0].oe == 1'b0 && o_split_gpio[1].oe == 1'b0
                          && o_split_gpio[2].oe == 1'b0 && o_split_gpio[3].oe == 1'b0)
  ) else $error("Split pin driven with global enable off");

  timeout_reset_a: assert property (
    $fell(i_rst) |-> (timeout_sel == `PSL_RST_TIMEOUT && toggle_ms == 12'h190)
  ) else $error("Timeout or toggle reset value wrong");

  no_timeout_a: assert property (
    (eff_timeout == 3'h0) [*2] |=> pulse == 2'h0
  ) else $error("Pulse with timeout disabled");

  read_idle_a: assert property (
    !i_reg_rd |=> o_reg_rdata == 8'h00
  ) else $error("Read data not cleared after read");

  port_en_store_a: assert property (
    (i_reg_wr && hit_port_en) |=> split_en_bits == $past(wr_port_bits)
  ) else $error("Split enable bits not stored");

  // Pin ownership must trace back to the select code one cycle earlier
  p5a_owner_a: assert property (
    o_split_gpio[0].oe |-> $past(p5_sel) == `PSL_P5_SEL_A
  ) else $error("Port 5 option A pin owned without select");

  p5b_owner_a: assert property (
    o_split_gpio[1].oe |-> $past(p5_sel) == `PSL_P5_SEL_B
  ) else $error("Port 5 option B pin owned without select");

  p6a_owner_a: assert property (
    o_split_gpio[2].oe |-> $past(p6_sel) == `PSL_P6_SEL_A
  ) else $error("Port 6 option A pin owned without select");

  p6b_owner_a: assert property (
    o_split_gpio[3].oe |-> $past(p6_sel) == `PSL_P6_SEL_B
  ) else $error("Port 6 option B pin owned without select");

  poly_off_a: assert property (
    !i_poly_fuse_mode |=> o_overcurrent == '0
  ) else $error("Overcurrent flagged outside poly fuse mode");

  p5_split_off_a: assert property (
    !split_on[0] |=> !pulse[0]
  ) else $error("Port 5 pulse while split disabled");

  p6_split_off_a: assert property (
    !split_on[1] |=> !pulse[1]
  ) else $error("Port 6 pulse while split disabled");

  reserved_timeout_a: assert property (
    (eff_timeout == 3'h7) |-> timeout_ms == 12'h000
  ) else $error("Reserved timeout code not treated as off");

endmodule // psl_top

// ---- verif/psl_far_model.sv ----
`timescale 1ns/1ps
module psl_far_model import psl_pkg::*; #(
  parameter int NUM_PORTS = 6
) (
  input wire logic i_ref_clk,
  input wire psl_od_pin_t [NUM_PORTS-1:0] i_pwr_ctl,
  input wire logic [NUM_PORTS-1:0] i_fuse_open,
  input wire logic i_moving,
  input wire logic [3:0] i_hold_code,
  output logic [NUM_PORTS-1:0] o_pwr_ctl_in,
  output psl_link_t o_link_state
);
  logic [3:0] walk;
  logic flip;
  initial begin
    walk = 4'h0;
    flip = 1'b0;
  end
  always @(posedge i_ref_clk) begin
    walk <= (walk == 4'hB) ? 4'h0 : walk + 4'h1;
    flip <= ~flip;
  end
  // Open fuse drops the anode low; a pin neither driven nor pulled floats
  always_comb begin
    for (int k = 0; k < NUM_PORTS; k++) begin
      if (i_pwr_ctl[k].oe) o_pwr_ctl_in[k] = 1'b0;
      else if (i_fuse_open[k]) o_pwr_ctl_in[k] = 1'b0;
      else if (i_pwr_ctl[k].pullup_en) o_pwr_ctl_in[k] = 1'b1;
      else o_pwr_ctl_in[k] = flip;
    end
  end
  // Healthy link walks through states; a stuck one holds one code
  assign o_link_state.p5 = i_moving ? walk : i_hold_code;
  assign o_link_state.p6 = i_moving ? walk : i_hold_code;
endmodule // psl_far_model

// ---- verif/psl_top_tb.sv ----
`timescale 1ns/1ps
`include "psl_defines.svh"
module psl_top_tb import psl_pkg::*;;
  localparam int CPM = 2;
  localparam int NP = 6;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [15:0] i_reg_addr = 16'h0000;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic i_otp_timeout_vld = 1'b0;
  logic [2:0] i_otp_timeout = 3'h0;
  logic i_poly_fuse_mode = 1'b0;
  logic [NP-1:0] i_port_power_en = 6'h00;
  logic [NP-1:0] fuse_open = 6'h00;
  logic moving = 1'b1;
  logic [3:0] hold_code = 4'h5;
  logic [NP-1:0] pin_in;
  psl_link_t link;
  logic [7:0] o_reg_rdata;
  psl_od_pin_t [NP-1:0] o_pwr_ctl;
  logic [NP-1:0] o_overcurrent;
  psl_pp_pin_t [3:0] o_split_gpio;
  int n_mismatch = 0;
  int samples_checked = 0;

  always #5 i_ref_clk = ~i_ref_clk;

  psl_top #(.NUM_PORTS(NP), .CYCLES_PER_MS(CPM)) uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_otp_timeout_vld(i_otp_timeout_vld),
    .i_otp_timeout(i_otp_timeout), .i_poly_fuse_mode(i_poly_fuse_mode),
    .i_port_power_en(i_port_power_en), .i_pwr_ctl_in(pin_in), .o_pwr_ctl(o_pwr_ctl),
    .o_overcurrent(o_overcurrent), .i_link_state(link), .o_split_gpio(o_split_gpio));

  psl_far_model #(.NUM_PORTS(NP)) far (.i_ref_clk(i_ref_clk), .i_pwr_ctl(o_pwr_ctl),
    .i_fuse_open(fuse_open), .i_moving(moving), .i_hold_code(hold_code),
    .o_pwr_ctl_in(pin_in), .o_link_state(link));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  function automatic logic win(input int v, input int lo, input int hi);
    return (v >= lo) && (v <= hi);
  endfunction

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(negedge i_ref_clk);
    i_reg_wr = 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [15:0] a, input logic [7:0] e);
    @(negedge i_ref_clk);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    @(negedge i_ref_clk);
    i_reg_rd = 1'b0;
    check(what, o_reg_rdata, e);
  endtask

  // Counts cycles until the split pin drops, then how long it stays low
  task automatic pulse_meas(input int limit, output int ts, output int tl);
    ts = 0;
    tl = 0;
    while (o_split_gpio[0].out === 1'b1 && ts < limit) begin
      @(negedge i_ref_clk);
      ts++;
    end
    check("oc_split", o_overcurrent, 6'h00);
    while (o_split_gpio[0].out === 1'b0 && tl < limit) begin
      @(negedge i_ref_clk);
      tl++;
    end
  endtask

  task automatic stuck_run(input logic [3:0] code, input int limit, output int ts, output int tl);
    @(negedge i_ref_clk);
    hold_code = code;
    moving = 1'b0;
    pulse_meas(limit, ts, tl);
  endtask

  task automatic relink();
    @(negedge i_ref_clk);
    moving = 1'b1;
    repeat (4) @(negedge i_ref_clk);
  endtask

  task automatic t_reset_regs();
    rd_chk("port_en", `PSL_OFF_PORT_EN, 8'h00);
    rd_chk("global", `PSL_OFF_GLOBAL, 8'h00);
    rd_chk("timeout", `PSL_OFF_TIMEOUT, 8'h05);
    rd_chk("toggle", `PSL_OFF_TOGGLE, 8'h05);
    rd_chk("unmapped", 16'h4170, 8'h00);
    wr(`PSL_OFF_PORT_EN, 8'hFF);
    rd_chk("port_en_rsvd", `PSL_OFF_PORT_EN, 8'h60);
    wr(`PSL_OFF_GLOBAL, 8'hFF);
    rd_chk("global_rsvd", `PSL_OFF_GLOBAL, 8'h01);
    wr(`PSL_OFF_PORT_EN, 8'h1E);
    rd_chk("port_en_1to4", `PSL_OFF_PORT_EN, 8'h00);
    wr(`PSL_OFF_GLOBAL, 8'h00);
    $display("t_reset_regs done");
  endtask

  task automatic t_power();
    repeat (2) @(negedge i_ref_clk);
    check("pwr_off", o_pwr_ctl, {6{3'b010}});
    i_port_power_en = 6'h3F;
    i_poly_fuse_mode = 1'b1;
    repeat (6) @(negedge i_ref_clk);
    check("pwr_on", o_pwr_ctl, {6{3'b001}});
    check("oc_none", o_overcurrent, 6'h00);
    fuse_open = 6'h24;
    repeat (8) @(negedge i_ref_clk);
    check("oc_fuse", o_overcurrent, 6'h24);
    i_port_power_en = 6'h1F;
    repeat (8) @(negedge i_ref_clk);
    check("oc_port_off", o_overcurrent, 6'h04);
    i_poly_fuse_mode = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    check("oc_no_poly", o_overcurrent, 6'h00);
    fuse_open = 6'h00;
    i_poly_fuse_mode = 1'b1;
    i_port_power_en = 6'h3F;
    repeat (8) @(negedge i_ref_clk);
    $display("t_power done");
  endtask

  task automatic t_split();
    wr(`PSL_OFF_P5_SEL, 8'h42);
    wr(`PSL_OFF_P6_SEL, 8'h04);
    wr(`PSL_OFF_PORT_EN, 8'h60);
    repeat (3) @(negedge i_ref_clk);
    check("gpio_no_global", o_split_gpio, 8'h00);
    wr(`PSL_OFF_GLOBAL, 8'h01);
    repeat (3) @(negedge i_ref_clk);
    check("gpio_on", o_split_gpio, 8'hC3);
    i_port_power_en = 6'h2F;
    repeat (3) @(negedge i_ref_clk);
    check("usb2_ctl", o_pwr_ctl[4], 3'b010);
    check("ss_pin", o_split_gpio, 8'hC3);
    i_port_power_en = 6'h3F;
    wr(`PSL_OFF_P5_SEL, 8'h05);
    wr(`PSL_OFF_P6_SEL, 8'h06);
    repeat (3) @(negedge i_ref_clk);
    check("gpio_opt", o_split_gpio, 8'h3C);
    wr(`PSL_OFF_GLOBAL, 8'h00);
    repeat (3) @(negedge i_ref_clk);
    check("gpio_global_off", o_split_gpio, 8'h00);
    wr(`PSL_OFF_P5_SEL, 8'h42);
    wr(`PSL_OFF_PORT_EN, 8'h20);
    wr(`PSL_OFF_GLOBAL, 8'h01);
    rd_chk("status", `PSL_OFF_STATUS, 8'h04);
    $display("t_split done");
  endtask

  task automatic t_timeouts();
    int ms [6] = '{100, 250, 500, 750, 1000, 2000};
    int ts;
    int tl;
    wr(`PSL_OFF_TOGGLE, 8'h00);
    for (int c = 1; c <= 6; c++) begin
      wr(`PSL_OFF_TIMEOUT, 8'(c));
      stuck_run(4'(c + 3), 5000, ts, tl);
      check("t_start", win(ts, ms[c-1] * CPM, ms[c-1] * CPM + 5), 1'b1);
      check("t_low", win(tl, 350 * CPM - 1, 350 * CPM + 1), 1'b1);
      relink();
    end
    $display("t_timeouts done");
  endtask

  task automatic t_no_pulse();
    int ts;
    int tl;
    wr(`PSL_OFF_TIMEOUT, 8'h07);
    stuck_run(4'h5, 600, ts, tl);
    check("code7", ts, 600);
    wr(`PSL_OFF_TIMEOUT, 8'h00);
    stuck_run(4'h5, 600, ts, tl);
    check("code0", ts, 600);
    relink();
    wr(`PSL_OFF_TIMEOUT, 8'h01);
    stuck_run(4'h3, 600, ts, tl);
    check("code_3", ts, 600);
    relink();
    stuck_run(4'hA, 600, ts, tl);
    check("code_A", ts, 600);
    relink();
    pulse_meas(600, ts, tl);
    check("moving", ts, 600);
    $display("t_no_pulse done");
  endtask

  task automatic t_restart_otp();
    int ts;
    int tl;
    wr(`PSL_OFF_TOGGLE, 8'h05);
    stuck_run(4'h8, 5000, ts, tl);
    check("low_400", win(tl, 800 - 1, 800 + 1), 1'b1);
    check("pin_back", o_split_gpio[0], 2'b11);
    pulse_meas(5000, ts, tl);
    check("restart", win(ts, 200 - 1, 200 + 5), 1'b1);
    relink();
    wr(`PSL_OFF_TIMEOUT, 8'h00);
    i_otp_timeout = 3'h1;
    i_otp_timeout_vld = 1'b1;
    stuck_run(4'h7, 5000, ts, tl);
    check("otp", win(ts, 200, 200 + 5), 1'b1);
    rd_chk("timeout_own", `PSL_OFF_TIMEOUT, 8'h00);
    relink();
    i_otp_timeout_vld = 1'b0;
    $display("t_restart_otp done");
  endtask

  initial begin
    repeat (40000) @(posedge i_ref_clk);
    n_mismatch++;
    $display("[ERR] watchdog expected finish seen timeout");
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_rst = 1'b0;
    t_reset_regs();
    t_power();
    t_split();
    t_timeouts();
    t_no_pulse();
    t_restart_otp();
    end_of_test();
  end
endmodule // psl_top_tb
